// >>> tb/tb_stop_sequencer.sv
// Purpose: Self-checking bench for the deep stop sequencer
// Assumes: Oscillator pins toggled by the bench, one edge per two clk
// Notes: Longest waits are checked as still pending, then reset mid-run
`timescale 1ns/1ps
module tb_stop_sequencer;
  import stop_pkg::*;
  logic clk, rst_n, stop_req, high_freq_clock, low_freq_clock;
  logic wake_irq, key_wakeup, resumed_r;
  warmup_cfg_t cfg_in;
  power_status_t status_r;
  int mismatches, num_checks, cycles;

  stop_sequencer u_stop_sequencer (
    .clk(clk), .rst_n(rst_n), .stop_req(stop_req), .cfg_in(cfg_in),
    .high_freq_clock(high_freq_clock), .low_freq_clock(low_freq_clock),
    .wake_irq(wake_irq), .key_wakeup(key_wakeup),
    .status_r(status_r), .resumed_r(resumed_r)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Ceiling sized for about 91k cycles of planned traffic
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 98000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp_st(input logic [4:0] got, input logic [4:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Wait is the longer of oscillator and flash warm-up
  function automatic int need(input logic [1:0] sel);
    int e;
    e = (sel == 2'h1) ? 8 : (sel == 2'h2) ? 14 : 16;
    need = ((1 << e) > 4096) ? (1 << e) : 4096;
  endfunction

  task automatic ticks(input logic low, input int n);
    repeat (n) begin
      @(posedge clk);
      if (low) low_freq_clock <= 1'b1;
      else high_freq_clock <= 1'b1;
      @(posedge clk);
      if (low) low_freq_clock <= 1'b0;
      else high_freq_clock <= 1'b0;
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    wake_irq <= 1'b0;
    key_wakeup <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    cmp_st(status_r, 5'h18);
  endtask

  // Part 0 runs to restart; else part ticks, still pending, then reset
  task automatic run(input logic [1:0] sel, input logic src, input int part);
    int n, k;
    logic key;
    n = need(sel);
    key = 1'($urandom_range(0, 1));
    @(posedge clk);
    stop_req <= 1'b1;
    cfg_in <= '{src_low: src, count_sel: sel};
    @(posedge clk);
    stop_req <= 1'b0;
    cfg_in <= warmup_cfg_t'(3'($urandom));
    #1;
    cmp_st(status_r, {4'h2, sel == 2'h0});
    // Oscillator edges while in deep stop must not count
    ticks(1'b0, $urandom_range(2, 6));
    ticks(1'b1, $urandom_range(2, 6));
    @(posedge clk);
    #1;
    cmp_st({status_r[4:1], 1'b0}, 5'h04);
    @(posedge clk);
    if (key) key_wakeup <= 1'b1;
    else wake_irq <= 1'b1;
    for (k = 0; k < 8 && status_r.warming !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    cmp_st(5'(k), 5'h03);
    cmp_st({status_r[4:1], 1'b0}, 5'h16);
    @(posedge clk);
    wake_irq <= 1'b0;
    key_wakeup <= 1'b0;
    ticks(src, (part == 0) ? n - 1 : part);
    ticks(!src, 4);
    @(posedge clk);
    #1;
    cmp_st({status_r[4:1], 1'b0}, 5'h16);
    if (part != 0) begin
      do_reset();
      return;
    end
    ticks(src, 1);
    for (k = 0; k < 12 && resumed_r !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    cmp_st({4'h0, resumed_r}, 5'h01);
    cmp_st({status_r[4:1], 1'b0}, 5'h18);
    @(posedge clk);
    #1;
    cmp_st({4'h0, resumed_r}, 5'h00);
  endtask

  initial begin
    void'($urandom(32'hC600));
    rst_n = 1'b0;
    stop_req = 1'b0;
    cfg_in = '0;
    high_freq_clock = 1'b0;
    low_freq_clock = 1'b0;
    wake_irq = 1'b0;
    key_wakeup = 1'b0;
    mismatches = 0;
    num_checks = 0;
    cycles = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    cmp_st(status_r, 5'h18);
    run(2'h1, 1'b0, 0);
    run(2'h1, 1'b1, 0);
    run(2'h2, 1'($urandom_range(0, 1)), 0);
    // Past the 2^14 mark, so only the longest wait can still be open
    run(2'h3, 1'b0, 16447);
    // Past the flash wait; cycle budget keeps this one shorter
    run(2'h0, 1'b1, 4159);
    print_verdict();
  end
endmodule

// >>> verilog/stop_pkg.sv
// Purpose: Shared constants and types for the deep stop sequencer
// Assumes: Oscillator clocks arrive as free pins, sampled on clk
// Notes: Tags below mark the logic that carries each rule
// Operation
// - Deep stop halts every circuit and oscillator
// - Clock held until both warm-ups expire
// - Select 01/10/11 gives 2^8/2^14/2^16 counts
// - Source bit 0 high clock, 1 low clock
// - Flash warm-up of 2^12 selected clock cycles
// - Interrupt releases stop, then warm-up runs
// - Release effective only after full warm-up
// - Wake sampled unclocked, restart synchronous; code samples wake through two flops on clk
package stop_pkg;
  localparam int CNT_W = 17;
  localparam int SYNC_W = 4;
  // Indices into the synchroniser vector
  localparam int SYN_HF = 0;
  localparam int SYN_LF = 1;
  localparam int SYN_IRQ = 2;
  localparam int SYN_KEY = 3;
  localparam logic [1:0] SEL_RSVD = 2'h0;
  localparam logic [1:0] SEL_2P8 = 2'h1;
  localparam logic [1:0] SEL_2P14 = 2'h2;
  localparam logic [1:0] SEL_2P16 = 2'h3;
  localparam logic [4:0] EXP_8 = 5'h08;
  localparam logic [4:0] EXP_14 = 5'h0E;
  localparam logic [4:0] EXP_16 = 5'h10;
  localparam logic [4:0] EXP_FLASH = 5'h0C;
  localparam logic SRC_HIGH = 1'b0;
  localparam logic SRC_LOW = 1'b1;

  typedef enum logic [1:0] {ST_RUN, ST_STOP, ST_WARM, ST_RESUME} stop_state_t;

  typedef struct packed {
    logic src_low;
    logic [1:0] count_sel;
  } warmup_cfg_t;

  typedef struct packed {
    logic osc_en;
    logic sys_clk_en;
    logic halted;
    logic warming;
    logic reserved_sel;
  } power_status_t;

  // Reserved code falls back to the longest wait
  function automatic logic [4:0] warmup_exp(input logic [1:0] sel);
    case (sel)
      SEL_2P8: warmup_exp = EXP_8;
      SEL_2P14: warmup_exp = EXP_14;
      default: warmup_exp = EXP_16;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] exp_target(input logic [4:0] e);
    exp_target = CNT_W'(1) << e;
  endfunction
endpackage

// >>> verilog/stop_sequencer.sv
// Purpose: Deep stop entry, wake-up and warm-up before clock restart
// Assumes: Oscillator and wake inputs are pins from outside clk's domain
// Notes: sys_clk_en gates the system clock; osc_en runs the oscillator
`timescale 1ns/1ps
module stop_sequencer
  import stop_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Stop request from the core, same domain
  input wire logic stop_req,
  input wire warmup_cfg_t cfg_in,
  // Oscillator pins
  input wire logic high_freq_clock,
  input wire logic low_freq_clock,
  // Wake sources, asynchronous
  input wire logic wake_irq,
  input wire logic key_wakeup,
  // Status
  output power_status_t status_r,
  output logic resumed_r
);
  stop_state_t state_r;
  stop_state_t state_nxt;
  warmup_cfg_t cfg_r;
  warmup_cfg_t cfg_nxt;
  power_status_t status_nxt;
  logic resumed_nxt;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [1:0] clk_d_r;
  logic hf_tick;
  logic lf_tick;
  logic sel_tick;
  logic wake;
  logic osc_done;
  logic flash_done;
  logic cnt_clear;

  // Every check in this block samples on clk and sleeps in reset
  default clocking cb_chk @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Pins pass two flops; stage two is read, plus a third flop on the oscillator pins for edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
      clk_d_r <= '0;
    end else begin
      sync1_r <= {key_wakeup, wake_irq, low_freq_clock, high_freq_clock};
      sync2_r <= sync1_r;
      clk_d_r <= sync2_r[SYN_LF:SYN_HF];
    end
  end

  always_comb begin
    hf_tick = sync2_r[SYN_HF] & ~clk_d_r[SYN_HF];
    lf_tick = sync2_r[SYN_LF] & ~clk_d_r[SYN_LF];
    // Counter follows the latched source bit
    sel_tick = (cfg_r.src_low == SRC_LOW) ? lf_tick : hf_tick;
    // Only counts during warm-up (ST_WARM), not while running in run or resume
    sel_tick = sel_tick && (state_r == ST_WARM);
    wake = sync2_r[SYN_IRQ] | sync2_r[SYN_KEY];
    cnt_clear = (state_r == ST_STOP);
  end

  warmup_counter #(.WIDTH(CNT_W)) u_osc_warm (
    .clk(clk),
    .rst_n(rst_n),
    .clear(cnt_clear),
    .tick(sel_tick),
    .exp_sel(warmup_exp(cfg_r.count_sel)),
    .done_r(osc_done)
  );

  // Flash wait runs alongside; restart waits for the longer
  warmup_counter #(.WIDTH(CNT_W)) u_flash_warm (
    .clk(clk),
    .rst_n(rst_n),
    .clear(cnt_clear),
    .tick(sel_tick),
    .exp_sel(EXP_FLASH),
    .done_r(flash_done)
  );

  always_comb begin
    state_nxt = state_r;
    cfg_nxt = cfg_r;
    resumed_nxt = 1'b0;
    case (state_r)
      ST_RUN: begin
        if (stop_req) begin
          state_nxt = ST_STOP;
          cfg_nxt = cfg_in;
        end
      end
      ST_STOP: begin
        if (wake) begin
          state_nxt = ST_WARM;
        end
      end
      ST_WARM: begin
        if (osc_done && flash_done) begin
          state_nxt = ST_RESUME;
        end
      end
      ST_RESUME: begin
        state_nxt = ST_RUN;
        resumed_nxt = 1'b1;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
    // Outputs derive from the next state so they leave flops
    status_nxt.osc_en = (state_nxt != ST_STOP);
    status_nxt.sys_clk_en = (state_nxt == ST_RUN) ||
                            (state_nxt == ST_RESUME);
    status_nxt.halted = (state_nxt == ST_STOP) || (state_nxt == ST_WARM);
    status_nxt.warming = (state_nxt == ST_WARM);
    status_nxt.reserved_sel = (cfg_nxt.count_sel == SEL_RSVD);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RUN;
      cfg_r <= '0;
      status_r <= '{osc_en: 1'b1, sys_clk_en: 1'b1, halted: 1'b0,
                    warming: 1'b0, reserved_sel: 1'b0};
      resumed_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cfg_r <= cfg_nxt;
      status_r <= status_nxt;
      resumed_r <= resumed_nxt;
    end
  end

  // Helper: selected ticks seen during warm-up
  logic [CNT_W:0] ticks_seen_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ticks_seen_r <= '0;
    end else if (state_r == ST_STOP) begin
      ticks_seen_r <= '0;
    end else if (sel_tick) begin
      ticks_seen_r <= ticks_seen_r + (CNT_W+1)'(1);
    end
  end

  a_stop_all_off: assert property (
    state_r == ST_STOP |-> !status_r.osc_en && !status_r.sys_clk_en)
    else $error("clock or oscillator running in stop");

  a_osc_off_stop: assert property (
    !status_r.osc_en |-> state_r == ST_STOP)
    else $error("oscillator stopped outside deep stop");

  a_halted_flag: assert property (
    status_r.halted == (state_r == ST_STOP || state_r == ST_WARM))
    else $error("halted flag does not match state");

  a_stop_holds: assert property (
    state_r == ST_STOP && !wake |=> state_r == ST_STOP)
    else $error("stop left without a wake source");

  a_warm_clk_held: assert property (
    state_r == ST_WARM |-> !status_r.sys_clk_en && status_r.osc_en)
    else $error("system clock ran during warm-up");

  a_resume_to_run: assert property (
    state_r == ST_RESUME |=> state_r == ST_RUN && resumed_r)
    else $error("restart did not return to run");

  a_restart_both_done: assert property (
    $rose(status_r.sys_clk_en) |-> $past(osc_done && flash_done))
    else $error("clock restarted before both waits ended");

  a_osc_count_met: assert property (
    state_r == ST_WARM && state_nxt == ST_RESUME |->
      ticks_seen_r >= {1'b0, exp_target(warmup_exp(cfg_r.count_sel))})
    else $error("oscillator warm-up too short");

  a_flash_count_met: assert property (
    state_r == ST_WARM && state_nxt == ST_RESUME |->
      ticks_seen_r >= {1'b0, exp_target(EXP_FLASH)})
    else $error("flash warm-up too short");

  a_flash_gate: assert property (
    state_r == ST_WARM && !flash_done |=> state_r == ST_WARM)
    else $error("warm-up left before flash wait ended");

  a_cfg_held: assert property (
    state_r != ST_RUN |=> $stable(cfg_r))
    else $error("warm-up config changed outside run");

  a_src_ignored: assert property (
    state_r == ST_WARM && cfg_r.src_low == SRC_LOW && hf_tick && !lf_tick
      |=> ticks_seen_r == $past(ticks_seen_r))
    else $error("counter advanced on the unselected clock");

  // Wake pins read raw here, so the sync delay is part of the check
  a_wake_to_warm: assert property (
    state_r == ST_STOP && (wake_irq || key_wakeup) ##1
      (wake_irq || key_wakeup) ##1 state_r == ST_STOP |=> state_r == ST_WARM)
    else $error("held wake did not start warm-up");

  a_rsvd_flag: assert property (
    state_r == ST_RUN && stop_req && cfg_in.count_sel == SEL_RSVD
      |=> status_r.reserved_sel ##1 state_r != ST_RUN)
    else $error("reserved select not flagged");

  a_resume_pulse: assert property (
    resumed_r |-> status_r.sys_clk_en ##1 !resumed_r)
    else $error("resume pulse malformed");

  c_stop_entry: cover property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_RUN && stop_req);
  c_key_wake: cover property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_STOP && sync2_r[SYN_KEY]);
  c_low_src_resume: cover property (@(posedge clk) disable iff (!rst_n)
    resumed_r && cfg_r.src_low == SRC_LOW);
  c_reserved_warm: cover property (status_r.reserved_sel && status_r.warming);
endmodule

// >>> verilog/warmup_counter.sv
// Purpose: Counts ticks of the selected clock up to 2^exp
// Assumes: tick is a one-cycle pulse on clk
// Notes: done_r is sticky until clear
`timescale 1ns/1ps
module warmup_counter
  import stop_pkg::*;
#(
  parameter int WIDTH = CNT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic tick,
  input wire logic [4:0] exp_sel,
  // Result
  output logic done_r
);
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic done_nxt;
  logic [WIDTH-1:0] target;

  always_comb begin
    target = WIDTH'(exp_target(exp_sel));
    count_nxt = count_r;
    done_nxt = done_r;
    if (clear) begin
      count_nxt = '0;
      done_nxt = 1'b0;
    end else if (tick && !done_r) begin
      count_nxt = count_r + WIDTH'(1);
      done_nxt = (count_nxt >= target);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
      done_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      done_r <= done_nxt;
    end
  end

  a_done_needs_count: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(done_r) |-> count_r >= target)
    else $error("warm-up done before target count");
endmodule
